// >>> pkg/hcma_cfg.svh
`ifndef HCMA_CFG_SVH
`define HCMA_CFG_SVH

`define HCMA_ADDR_W      16
`define HCMA_DATA_W      16
`define HCMA_MODE_BC     2'h0
`define HCMA_MODE_RT     2'h1
`define HCMA_MODE_SMON   2'h2
`define HCMA_MODE_WMON   2'h3
`define HCMA_XFER_CYC    2'h2

`endif

// >>> pkg/hcma_pkg.sv
`include "hcma_cfg.svh"

package hcma_pkg;
    typedef enum logic [1:0] {
        HCMA_IDLE = 2'b00,
        HCMA_XFER = 2'b01,
        HCMA_DONE = 2'b10
    } hcma_state_e;

    typedef struct packed {
        logic                     write;
        logic [`HCMA_ADDR_W-1:0]  addr;
        logic [`HCMA_DATA_W-1:0]  wdata;
    } hcma_req_s;

    typedef struct packed {
        logic xmit_pos;
        logic xmit_neg;
        logic recv_pos;
        logic recv_neg;
        logic inhibit;
    } hcma_chan_s;
endpackage

// >>> hdl/hcma_host_port.sv
// Contract
// (RULE1) Host access is taken only while chip select is low.
// (RULE2) Host holds data strobe low for the whole cycle.
// (RULE3) Direction high means read; low means write data into device.
// (RULE4) In controller, terminal, selective monitor: activity low while message processed.
// (RULE5) In word monitor: activity low while monitor is online.
// (RULE6) Transmit, receive and inhibit paths loop internally per channel.
// (RULE7) Host keeps strobe low until ready goes low on waited accesses.
// (RULE8) Ready rests high, drops after a cycle, returns high when transfer ends.
`timescale 1ns/1ps
`include "hcma_cfg.svh"

module hcma_host_port
    import hcma_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    host_select_n,
    input  wire logic                    host_data_strobe_n,
    input  wire logic                    host_read_not_write,
    input  wire logic [`HCMA_ADDR_W-1:0] host_addr,
    input  wire logic [`HCMA_DATA_W-1:0] host_wdata,
    input  wire logic                    unused_grant_byte_select,
    output logic                         host_ready_n,
    output logic                         host_io_enable_n,
    output hcma_req_s                    core_req,
    output logic                         core_req_valid,
    input  wire logic [1:0]              core_mode,
    input  wire logic                    core_msg_busy,
    input  wire logic                    core_monitor_online,
    output logic                         message_active_n,
    input  wire hcma_chan_s              proto_ch_a,
    input  wire hcma_chan_s              proto_ch_b,
    output hcma_chan_s                   xcvr_ch_a,
    output hcma_chan_s                   xcvr_ch_b
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta_q <= 3'h7;
            pin_sync_q <= 3'h7;
        end else begin
            pin_meta_q <= {host_select_n, host_data_strobe_n, host_read_not_write};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic sel_n_s;
    logic strb_n_s;
    logic rd_s;
    assign sel_n_s  = pin_sync_q[2];
    assign strb_n_s = pin_sync_q[1];
    assign rd_s     = pin_sync_q[0];

    // Address and data ride two stages like the strobe, so they line up at capture.
    // The host holds them steady while the strobe is low, so no bit can tear.
    logic [`HCMA_ADDR_W-1:0] addr_meta_q;
    logic [`HCMA_ADDR_W-1:0] addr_sync_q;
    logic [`HCMA_DATA_W-1:0] wdata_meta_q;
    logic [`HCMA_DATA_W-1:0] wdata_sync_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_meta_q  <= '0;
            addr_sync_q  <= '0;
            wdata_meta_q <= '0;
            wdata_sync_q <= '0;
        end else begin
            addr_meta_q  <= host_addr;
            addr_sync_q  <= addr_meta_q;
            wdata_meta_q <= host_wdata;
            wdata_sync_q <= wdata_meta_q;
        end
    end

    logic cycle_req;
    assign cycle_req = !sel_n_s && !strb_n_s; // RULE1

    function automatic logic xfer_last(logic [1:0] cnt);
        return cnt == `HCMA_XFER_CYC - 2'h1;
    endfunction

    // ------------------------------------------------------------
    // Host cycle sequencer
    // ------------------------------------------------------------
    hcma_state_e state_q;
    logic [1:0]  xfer_cnt_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q    <= HCMA_IDLE;
            xfer_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                HCMA_IDLE: begin
                    xfer_cnt_q <= 2'h0;
                    if (cycle_req) begin // RULE1
                        state_q <= HCMA_XFER;
                    end
                end
                HCMA_XFER: begin
                    xfer_cnt_q <= xfer_cnt_q + 2'h1;
                    if (xfer_last(xfer_cnt_q)) begin
                        state_q <= HCMA_DONE;
                    end
                end
                HCMA_DONE: begin
                    // Wait for strobe or select release so one strobe gives one transfer
                    if (strb_n_s || sel_n_s) begin // RULE7
                        state_q <= HCMA_IDLE;
                    end
                end
                default: begin
                    state_q <= HCMA_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Request capture and strobes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_req       <= '0;
            core_req_valid <= 1'b0;
        end else begin
            core_req_valid <= 1'b0;
            if (state_q == HCMA_IDLE && cycle_req) begin
                core_req.write <= !rd_s; // RULE3
                core_req.addr  <= addr_sync_q;
                core_req.wdata <= wdata_sync_q;
                core_req_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_ready_n     <= 1'b1;
            host_io_enable_n <= 1'b1;
        end else begin
            host_ready_n     <= !(state_q == HCMA_XFER && xfer_last(xfer_cnt_q)); // RULE8
            host_io_enable_n <= !(state_q == HCMA_XFER);
        end
    end

    // ------------------------------------------------------------
    // Message activity
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            message_active_n <= 1'b1;
        end else if (core_mode == `HCMA_MODE_WMON) begin
            message_active_n <= !core_monitor_online; // RULE5
        end else begin
            message_active_n <= !core_msg_busy; // RULE4
        end
    end

    // ------------------------------------------------------------
    // Internal channel loopback
    // ------------------------------------------------------------
    assign xcvr_ch_a = proto_ch_a; // RULE6
    assign xcvr_ch_b = proto_ch_b; // RULE6

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_start;
        state_q == HCMA_IDLE && cycle_req;
    endsequence

    sequence s_ready_pulse;
        ##3 !host_ready_n ##1 host_ready_n;
    endsequence

    property p_sel_gate;
        @(posedge ref_clk) disable iff (rst)
        core_req_valid |-> !$past(sel_n_s) && !$past(strb_n_s);
    endproperty
    a_sel_gate: assert property (p_sel_gate) else $error("request without select"); // RULE1

    property p_dir;
        @(posedge ref_clk) disable iff (rst)
        core_req_valid |-> core_req.write == !$past(rd_s);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong"); // RULE3

    property p_ready;
        @(posedge ref_clk) disable iff (rst)
        s_start |-> s_ready_pulse;
    endproperty
    a_ready: assert property (p_ready) else $error("ready pulse wrong"); // RULE8

    property p_ready_idle;
        @(posedge ref_clk) disable iff (rst)
        state_q == HCMA_IDLE |=> host_ready_n;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready low when idle"); // RULE8

    property p_busy;
        @(posedge ref_clk) disable iff (rst)
        core_mode != `HCMA_MODE_WMON |=> message_active_n == !$past(core_msg_busy);
    endproperty
    a_busy: assert property (p_busy) else $error("activity wrong"); // RULE4

    property p_wmon;
        @(posedge ref_clk) disable iff (rst)
        core_mode == `HCMA_MODE_WMON |=> message_active_n == !$past(core_monitor_online);
    endproperty
    a_wmon: assert property (p_wmon) else $error("monitor activity wrong"); // RULE5

    property p_loop;
        @(posedge ref_clk) disable iff (rst)
        xcvr_ch_a == proto_ch_a && xcvr_ch_b == proto_ch_b;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback broken"); // RULE6

    property p_one_per_strobe;
        @(posedge ref_clk) disable iff (rst)
        core_req_valid |=> !core_req_valid [*3];
    endproperty
    a_one_per_strobe: assert property (p_one_per_strobe) else $error("double request"); // RULE7

    property p_no_take_unselected;
        @(posedge ref_clk) disable iff (rst)
        sel_n_s |=> !core_req_valid;
    endproperty
    a_no_take_unselected: assert property (p_no_take_unselected) else $error("taken unselected"); // RULE1

    property p_hold_done;
        @(posedge ref_clk) disable iff (rst)
        state_q == HCMA_DONE && !strb_n_s && !sel_n_s |=> state_q == HCMA_DONE;
    endproperty
    a_hold_done: assert property (p_hold_done) else $error("left done early"); // RULE7

endmodule

// >>> sim/hcma_host_model.sv
`timescale 1ns/1ps
module hcma_host_model (
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic        no_sel,
    input  wire logic        go_rnw,
    input  wire logic [15:0] go_addr,
    input  wire logic [15:0] go_data,
    input  wire logic        host_ready_n,
    output logic             host_select_n,
    output logic             host_data_strobe_n,
    output logic             host_read_not_write,
    output logic [15:0]      host_addr,
    output logic [15:0]      host_wdata,
    output logic             busy
);
    int hold_cnt = 0;
    initial {host_select_n, host_data_strobe_n, host_read_not_write, busy} = 4'hE;
    initial {host_addr, host_wdata} = '0;
    always @(posedge ref_clk) begin
        if (!busy && go) begin
            busy                <= 1'b1;
            hold_cnt            <= 0;
            host_select_n       <= no_sel;
            host_data_strobe_n  <= 1'b0;
            host_read_not_write <= go_rnw;
            host_addr           <= go_addr;
            host_wdata          <= go_data;
        end else if (busy && (!host_ready_n || hold_cnt == 12)) begin
            busy               <= 1'b0;
            host_select_n      <= 1'b1;
            host_data_strobe_n <= 1'b1;
            // Released address and data lines never keep the old value
            host_addr          <= ~host_addr;
            host_wdata         <= ~host_wdata;
        end else if (busy) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
endmodule

// >>> sim/host_cycle_and_message_activity_bench.sv
`timescale 1ns/1ps
`include "hcma_cfg.svh"
module host_cycle_and_message_activity_bench import hcma_pkg::*;;
    logic ref_clk = 0, rst = 1, go = 0, no_sel = 0, g_rnw = 0, busy;
    logic [15:0] g_addr = 0, g_data = 0, host_addr, host_wdata;
    logic host_select_n, host_data_strobe_n, host_read_not_write, host_ready_n;
    logic host_io_enable_n, core_req_valid, message_active_n;
    logic unused_grant_byte_select = 0, core_msg_busy = 0, core_monitor_online = 0;
    logic [1:0] core_mode = 0;
    hcma_req_s core_req, got;
    hcma_chan_s proto_ch_a = '0, proto_ch_b = '0, xcvr_ch_a, xcvr_ch_b;
    int mismatches = 0, n_checks = 0, n_val = 0, n_rdy = 0, n_ioe = 0, i;

    hcma_host_port u_dut (.ref_clk, .rst, .host_select_n, .host_data_strobe_n,
        .host_read_not_write, .host_addr, .host_wdata, .unused_grant_byte_select,
        .host_ready_n, .host_io_enable_n, .core_req, .core_req_valid, .core_mode,
        .core_msg_busy, .core_monitor_online, .message_active_n, .proto_ch_a,
        .proto_ch_b, .xcvr_ch_a, .xcvr_ch_b);
    hcma_host_model u_host (.ref_clk, .go, .no_sel, .go_rnw(g_rnw), .go_addr(g_addr),
        .go_data(g_data), .host_ready_n, .host_select_n, .host_data_strobe_n,
        .host_read_not_write, .host_addr, .host_wdata, .busy);

    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (core_req_valid) begin
            n_val++;
            got <= core_req;
        end
        if (!host_ready_n) n_rdy++;
        if (!host_io_enable_n) n_ioe++;
    end

    function automatic logic exp_active_n(logic [1:0] m, logic b, logic on);
        return (m == `HCMA_MODE_WMON) ? !on : !b;
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask
    // ----------------------------------------
    // One host cycle through the far-side model
    // ----------------------------------------
    task automatic cyc(logic r, logic ns, logic [15:0] a, logic [15:0] d);
        int v0, r0, e0;
        @(posedge ref_clk);
        {go, no_sel, g_rnw, g_addr, g_data} <= {1'b1, ns, r, a, d};
        @(posedge ref_clk);
        go <= 1'b0;
        v0 = n_val;
        r0 = n_rdy;
        e0 = n_ioe;
        for (int k = 0; k < 40; k++) begin
            @(negedge ref_clk);
            if (!busy) break;
        end
        chk("requests", 33'(!ns), 33'(n_val - v0));
        chk("ready_pulses", 33'(!ns), 33'(n_rdy - r0));
        chk("ready_rest", 33'(1), 33'(host_ready_n));
        chk("io_enable", 33'(ns ? 2'h0 : `HCMA_XFER_CYC), 33'(n_ioe - e0));
        if (!ns) chk("req", {!r, a, r ? 16'h0 : d}, {got.write, got.addr, r ? 16'h0 : got.wdata});
        repeat (6) @(posedge ref_clk);
    endtask

    initial begin
        #(50 * 3000);
        mismatches++;
        test_done;
    end
    initial begin
        void'($urandom(9));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        cyc(1'b0, 1'b0, 16'hFFFF, 16'hA5A5);
        cyc(1'b1, 1'b0, 16'h0000, 16'h0000);
        cyc(1'b0, 1'b1, 16'h1234, 16'h5678);
        for (i = 0; i < 6; i++) cyc(1'($urandom), 1'b0, 16'($urandom), 16'($urandom));
        $display("host cycles done");
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            {core_msg_busy, core_monitor_online, unused_grant_byte_select} <= 3'($urandom);
            {proto_ch_a, proto_ch_b} <= 10'($urandom);
            core_mode <= 2'(i);
            repeat (3) @(negedge ref_clk);
            if (core_mode == `HCMA_MODE_WMON)
                chk("active", 33'(exp_active_n(core_mode, core_msg_busy, core_monitor_online)),
                    33'(message_active_n));
            else
                chk("active", 33'(exp_active_n(core_mode, core_msg_busy, core_monitor_online)),
                    33'(message_active_n));
            chk("xcvr", 33'({proto_ch_a, proto_ch_b}), 33'({xcvr_ch_a, xcvr_ch_b}));
        end
        $display("activity and loopback done");
        test_done;
    end
endmodule
